// [include/dcec_pkg.sv]
// Constants shared by the channel event control block
package dcec_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets on the bus
  // ---------------------------------------------------------------
  localparam logic [7:0] DCEC_OFF_ECON = 8'h00; // Event control
  localparam logic [7:0] DCEC_OFF_STAT = 8'h04; // Sticky events, W1C
  localparam logic [7:0] DCEC_OFF_MASK = 8'h08; // Interrupt enables
  localparam logic [7:0] DCEC_OFF_LIVE = 8'h0c; // Live channel state

  // ---------------------------------------------------------------
  // Event control field layout
  // ---------------------------------------------------------------
  localparam int DCEC_SEL_W       = 8;  // Selector width
  localparam int DCEC_ABT_SEL_LSB = 16; // Abort selector low bit
  localparam int DCEC_ABT_SEL_MSB = 23; // Abort selector high bit
  localparam int DCEC_STR_SEL_LSB = 8;  // Start selector low bit
  localparam int DCEC_STR_SEL_MSB = 15; // Start selector high bit
  localparam int DCEC_BIT_FORCE   = 7;  // Force-transfer command
  localparam int DCEC_BIT_ABORT   = 6;  // Abort command
  localparam int DCEC_BIT_PATTERN_ABORT_ENABLE   = 5;  // Pattern abort enable
  localparam int DCEC_BIT_SEN     = 4;  // Start request enable
  localparam int DCEC_BIT_AEN     = 3;  // Abort request enable

  // Reset values of the control fields
  localparam logic [7:0] DCEC_SEL_RST = 8'hff; // Selectors reset all ones
  localparam logic       DCEC_EN_RST  = 1'b0;  // Enables reset clear

  // ---------------------------------------------------------------
  // Event status bit positions (status and mask share layout)
  // ---------------------------------------------------------------
  localparam int DCEC_EV_W     = 5;
  localparam int DCEC_EV_START = 0; // Start by interrupt request
  localparam int DCEC_EV_FORCE = 1; // Start by software force
  localparam int DCEC_EV_IRQAB = 2; // Abort by interrupt request
  localparam int DCEC_EV_CMDAB = 3; // Abort by software command
  localparam int DCEC_EV_PATAB = 4; // Abort by pattern match

  // Live state bit positions
  localparam int DCEC_LV_BUSY = 0; // Engine transfer in progress
  localparam int DCEC_LV_AFLG = 1; // Abort event flag

  // Bus answer state machine, one-hot
  typedef enum logic [1:0] {
    DCEC_ST_IDLE = 2'b01,
    DCEC_ST_DONE = 2'b10
  } dcec_bus_st_t;

endpackage

// [rtl/dcec_irq_pick.sv]
// Matches one selected interrupt request line against a selector
`timescale 1ns/10ps
module dcec_irq_pick #(
  parameter int N_IRQ = 256,
  parameter int SEL_W = 8
) (
  // Request lines, one-cycle pulses
  input  wire logic [N_IRQ-1:0] irq_pulse,
  // Selection
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             enable,
  // Result
  output logic                  hit
);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  // Disabled selector ignores its line entirely
  always_comb begin
    hit = enable & irq_pulse[sel];
  end

endmodule

// [rtl/dcec_sticky.sv]
// Sticky event status with write-one-to-clear and mask
`timescale 1ns/10ps
module dcec_sticky #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Events and software clear
  input  wire logic [W-1:0] ev_set,
  input  wire logic [W-1:0] ev_clr,
  input  wire logic [W-1:0] mask,
  // Results
  output logic [W-1:0]      status_q,
  output logic              irq_q
);

  logic [W-1:0] status_d; // Next status
  logic         irq_d;    // Next interrupt level

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Set beats clear so an event in the clear cycle is kept
  always_comb begin
    status_d = (status_q & ~ev_clr) | ev_set;
    irq_d    = |(status_d & mask);
  end

  // Registers only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= irq_d;
    end
  end

endmodule

// [rtl/dcec_top.sv]
// DMA channel event control: start and abort selection with APB registers
`timescale 1ns/10ps
module dcec_top
  import dcec_pkg::*;
#(
  parameter int N_IRQ = 256,
  parameter int SEL_W = 8
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Interrupt request sources, one-cycle pulses
  input  wire logic [N_IRQ-1:0]          irq_pulse,
  // Channel transfer engine
  input  wire logic                      xfer_busy,
  input  wire logic                      pattern_match,
  output logic                           xfer_start,
  output logic                           xfer_abort,
  output logic                           channel_enable_clr,
  output logic                           abort_event_flag_set,
  // Interrupt to the system
  output logic                           irq
);

  import dcec_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Selector must reach every line and fit its field
  if (SEL_W != DCEC_SEL_W || N_IRQ != (1 << SEL_W)) begin : g_chk
    $error("dcec_top: N_IRQ must equal 2**SEL_W and SEL_W must be 8");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Control fields
  logic [SEL_W-1:0] abt_sel_q, abt_sel_d;   // Abort interrupt number
  logic [SEL_W-1:0] str_sel_q, str_sel_d;   // Start interrupt number
  logic             pattern_abort_enable_q, pattern_abort_enable_d;       // Pattern abort enable
  logic             sen_q, sen_d;           // Start request enable
  logic             aen_q, aen_d;           // Abort request enable
  logic [DCEC_EV_W-1:0] mask_q, mask_d;     // Interrupt mask
  // Command strobes from a completed write
  logic             force_cmd_q, force_cmd_d;
  logic             abort_cmd_q, abort_cmd_d;
  // Engine-facing pulses
  logic             start_q, start_d;
  logic             abort_q, abort_d;
  logic             cen_clr_q, cen_clr_d;
  logic             aflg_set_q, aflg_set_d;
  logic             aflg_q, aflg_d;         // Abort flag, for reading
  // Bus answer
  dcec_bus_st_t     st_q, st_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;
  logic [31:0]      prdata_q, prdata_d;
  // Internal combinational, then u_sticky register outputs
  logic             str_hit;                // Start interrupt seen
  logic             abt_hit;                // Abort interrupt seen
  logic             pat_hit;                // Gated pattern match
  logic             wr_done;                // Write completes now
  logic             addr_ok;                // Address is mapped
  logic [DCEC_EV_W-1:0] ev_set;             // Events this cycle
  logic [DCEC_EV_W-1:0] ev_clr;             // Software clears
  logic [DCEC_EV_W-1:0] status;             // Sticky status
  logic             irq_q;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Register image of event control; command and free bits read zero
  function automatic logic [31:0] econ_img(
    input logic [SEL_W-1:0] a,
    input logic [SEL_W-1:0] s,
    input logic             p,
    input logic             se,
    input logic             ae
  );
    logic [31:0] v;
    v = '0;
    v[DCEC_ABT_SEL_MSB:DCEC_ABT_SEL_LSB] = a;
    v[DCEC_STR_SEL_MSB:DCEC_STR_SEL_LSB] = s;
    v[DCEC_BIT_PATTERN_ABORT_ENABLE] = p;
    v[DCEC_BIT_SEN]   = se;
    v[DCEC_BIT_AEN]   = ae;
    return v;
  endfunction

  // One-cycle pulse when a written bit is one
  function automatic logic wr_one(
    input logic        wr,
    input logic [31:0] d,
    input int          pos
  );
    return wr & d[pos];
  endfunction

  // ---------------------------------------------------------------
  // Interrupt request matching
  // ---------------------------------------------------------------
  // Start line gated by its enable
  dcec_irq_pick #(
    .N_IRQ (N_IRQ),
    .SEL_W (SEL_W)
  ) u_pick_start (
    .irq_pulse (irq_pulse),
    .sel       (str_sel_q),
    .enable    (sen_q),
    .hit       (str_hit)
  );

  // Abort line gated by its enable
  dcec_irq_pick #(
    .N_IRQ (N_IRQ),
    .SEL_W (SEL_W)
  ) u_pick_abort (
    .irq_pulse (irq_pulse),
    .sel       (abt_sel_q),
    .enable    (aen_q),
    .hit       (abt_hit)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  always_comb begin
    addr_ok = (paddr == DCEC_OFF_ECON) || (paddr == DCEC_OFF_STAT) ||
              (paddr == DCEC_OFF_MASK) || (paddr == DCEC_OFF_LIVE);
    // Effect only at the edge where the master sees pready
    wr_done = psel & penable & pready_q & pwrite & addr_ok;
  end

  // ---------------------------------------------------------------
  // Bus answer state machine
  // ---------------------------------------------------------------
  // Answer one cycle into the access phase, then drop pready
  always_comb begin
    st_d      = st_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = '0;
    case (st_q)
      DCEC_ST_IDLE: begin
        if (psel && penable) begin
          st_d      = DCEC_ST_DONE;
          pready_d  = 1'b1;
          pslverr_d = ~addr_ok;   // Unmapped: error, data zero
          if (!pwrite) begin
            case (paddr)
              DCEC_OFF_ECON:
                prdata_d = econ_img(abt_sel_q, str_sel_q, pattern_abort_enable_q,
                                    sen_q, aen_q);
              DCEC_OFF_STAT: prdata_d[DCEC_EV_W-1:0] = status;
              DCEC_OFF_MASK: prdata_d[DCEC_EV_W-1:0] = mask_q;
              DCEC_OFF_LIVE: begin
                prdata_d[DCEC_LV_BUSY] = xfer_busy;
                prdata_d[DCEC_LV_AFLG] = aflg_q;
              end
              default:       prdata_d = '0;
            endcase
          end
        end
      end
      DCEC_ST_DONE: begin
        // Master releases the request after the completing edge
        st_d = DCEC_ST_IDLE;
      end
      default: begin
        st_d = DCEC_ST_IDLE;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q      <= DCEC_ST_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      st_q      <= st_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Control register writes
  // ---------------------------------------------------------------
  // Only implemented fields are taken from the write data
  always_comb begin
    abt_sel_d   = abt_sel_q;
    str_sel_d   = str_sel_q;
    pattern_abort_enable_d     = pattern_abort_enable_q;
    sen_d       = sen_q;
    aen_d       = aen_q;
    mask_d      = mask_q;
    force_cmd_d = 1'b0;
    abort_cmd_d = 1'b0;
    ev_clr      = '0;
    if (wr_done && paddr == DCEC_OFF_ECON) begin
      abt_sel_d = pwdata[DCEC_ABT_SEL_MSB:DCEC_ABT_SEL_LSB];
      str_sel_d = pwdata[DCEC_STR_SEL_MSB:DCEC_STR_SEL_LSB];
      pattern_abort_enable_d   = pwdata[DCEC_BIT_PATTERN_ABORT_ENABLE];
      sen_d     = pwdata[DCEC_BIT_SEN];
      aen_d     = pwdata[DCEC_BIT_AEN];
      // Commands never stored; a zero written is no command
      force_cmd_d = wr_one(1'b1, pwdata, DCEC_BIT_FORCE);
      abort_cmd_d = wr_one(1'b1, pwdata, DCEC_BIT_ABORT);
    end
    if (wr_done && paddr == DCEC_OFF_MASK) begin
      mask_d = pwdata[DCEC_EV_W-1:0];
    end
    if (wr_done && paddr == DCEC_OFF_STAT) begin
      ev_clr = pwdata[DCEC_EV_W-1:0];
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      abt_sel_q   <= DCEC_SEL_RST;
      str_sel_q   <= DCEC_SEL_RST;
      pattern_abort_enable_q     <= DCEC_EN_RST;
      sen_q       <= DCEC_EN_RST;
      aen_q       <= DCEC_EN_RST;
      mask_q      <= '0;
      force_cmd_q <= 1'b0;
      abort_cmd_q <= 1'b0;
    end else begin
      abt_sel_q   <= abt_sel_d;
      str_sel_q   <= str_sel_d;
      pattern_abort_enable_q     <= pattern_abort_enable_d;
      sen_q       <= sen_d;
      aen_q       <= aen_d;
      mask_q      <= mask_d;
      force_cmd_q <= force_cmd_d;
      abort_cmd_q <= abort_cmd_d;
    end
  end

  // ---------------------------------------------------------------
  // Start and abort decisions
  // ---------------------------------------------------------------
  // Abort sources win over starts landing in the same cycle, so an
  // engine never sees both pulses together
  always_comb begin
    pat_hit    = pattern_abort_enable_q & pattern_match;
    abort_d    = abt_hit | abort_cmd_q | pat_hit;
    start_d    = (str_hit | force_cmd_q) & ~abort_d;
    cen_clr_d  = pat_hit;
    aflg_set_d = abt_hit;
    aflg_d     = aflg_q | abt_hit;
    // Flag mirror follows the status bit clear
    if (ev_clr[DCEC_EV_IRQAB] && !abt_hit) begin
      aflg_d = 1'b0;
    end
    ev_set                = '0;
    ev_set[DCEC_EV_START] = str_hit & ~abort_d;
    ev_set[DCEC_EV_FORCE] = force_cmd_q & ~abort_d;
    ev_set[DCEC_EV_IRQAB] = abt_hit;
    ev_set[DCEC_EV_CMDAB] = abort_cmd_q;
    ev_set[DCEC_EV_PATAB] = pat_hit;
  end

  // Engine pulse registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_q    <= 1'b0;
      abort_q    <= 1'b0;
      cen_clr_q  <= 1'b0;
      aflg_set_q <= 1'b0;
      aflg_q     <= 1'b0;
    end else begin
      start_q    <= start_d;
      abort_q    <= abort_d;
      cen_clr_q  <= cen_clr_d;
      aflg_set_q <= aflg_set_d;
      aflg_q     <= aflg_d;
    end
  end

  // ---------------------------------------------------------------
  // Event status and interrupt
  // ---------------------------------------------------------------
  dcec_sticky #(
    .W (DCEC_EV_W)
  ) u_sticky (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ev_set   (ev_set),
    .ev_clr   (ev_clr),
    .mask     (mask_q),
    .status_q (status),
    .irq_q    (irq_q)
  );

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign pready               = pready_q;
  assign prdata               = prdata_q;
  assign pslverr              = pslverr_q;
  assign xfer_start           = start_q;
  assign xfer_abort           = abort_q;
  assign channel_enable_clr   = cen_clr_q;
  assign abort_event_flag_set = aflg_set_q;
  assign irq                  = irq_q;

endmodule

// [verification/dcec_engine_model.sv]
// Behavioural model of the channel transfer engine
`timescale 1ns/10ps
module dcec_engine_model #(
  parameter int LEN = 16  // Cells per transfer, plain default
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Commands from the block
  input  wire logic xfer_start,
  input  wire logic xfer_abort,
  // Bench request for a pattern hit
  input  wire logic match_req,
  // Engine state
  output logic      xfer_busy,
  output logic      pattern_match
);
  logic [7:0] cnt_q;  // Cells left to move
  logic [7:0] cnt_d;
  logic       pm_d;
  // Next state: abort beats start, as on real hardware
  always_comb begin
    cnt_d = cnt_q;
    if (xfer_abort) begin
      cnt_d = 8'h00;
    end else if (xfer_start) begin
      cnt_d = 8'(LEN);
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
    // Matches only while data moves
    pm_d = match_req && cnt_q != 8'h00;
  end
  // Registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      pattern_match <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pattern_match <= pm_d;
    end
  end
  assign xfer_busy = cnt_q != 8'h00;
endmodule

// [verification/dcec_checker.sv]
// Assertion checker bound to the channel event control top
`timescale 1ns/10ps
module dcec_checker
  import dcec_pkg::*;
#(
  parameter int N_IRQ = 256,
  parameter int SEL_W = 8
) (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  // Channel side
  input wire logic [N_IRQ-1:0] irq_pulse,
  input wire logic             pattern_match,
  input wire logic             xfer_start,
  input wire logic             xfer_abort,
  input wire logic             channel_enable_clr,
  input wire logic             abort_event_flag_set,
  input wire logic             irq
);
  // -----------------------------------------------------------
  // Shadow of event control, updated when a write completes
  // -----------------------------------------------------------
  logic [SEL_W-1:0] as_q, as_d;  // Abort selector
  logic [SEL_W-1:0] ss_q, ss_d;  // Start selector
  logic [2:0]       en_q, en_d;  // Pattern, start, abort enables
  logic             wr, wf, wa, hs, ha, pat;
  // Decode and next values
  always_comb begin
    wr = psel && penable && pready && pwrite && paddr == DCEC_OFF_ECON;
    wf = wr && pwdata[7];
    wa = wr && pwdata[6];
    as_d = wr ? pwdata[23:16] : as_q;
    ss_d = wr ? pwdata[15:8] : ss_q;
    en_d = wr ? pwdata[5:3] : en_q;
    hs = irq_pulse[ss_q] && en_q[1];
    ha = irq_pulse[as_q] && en_q[0];
    pat = pattern_match && en_q[2];
  end
  // Shadow registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      as_q <= DCEC_SEL_RST;
      ss_q <= DCEC_SEL_RST;
      en_q <= 3'h0;
    end else begin
      as_q <= as_d;
      ss_q <= ss_d;
      en_q <= en_d;
    end
  end
  // -----------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_irq_start: assert property (hs && !ha && !pat && !$past(wa) |=>
    xfer_start)
    else $error("start request did not start");
  a_start_cause: assert property (xfer_start |->
    $past(hs) || $past(wf, 2) || $past(wf, 3))
    else $error("start without cause");
  a_irq_abort: assert property (ha || pat |=> xfer_abort && !xfer_start)
    else $error("abort request ignored");
  a_abort_cause: assert property (xfer_abort |->
    $past(ha || pat) || $past(wa, 2) || $past(wa, 3))
    else $error("abort without cause");
  a_abort_flag: assert property (ha |=> abort_event_flag_set)
    else $error("abort flag not set");
  a_pattern_clear: assert property (pat |=> channel_enable_clr)
    else $error("pattern match did not clear enable");
  a_clear_cause: assert property (channel_enable_clr |-> $past(pat))
    else $error("enable cleared without pattern abort");
  a_force_start: assert property (wf && !pwdata[6] |->
    ##[1:2] (xfer_start || xfer_abort))
    else $error("force did not start");
  a_cmd_abort: assert property (wa |-> ##[1:2] xfer_abort)
    else $error("abort command ignored");
  a_econ_read: assert property (psel && penable && pready && !pwrite &&
    paddr == DCEC_OFF_ECON |->
    prdata == {8'h00, as_q, ss_q, 2'b00, en_q, 3'b000})
    else $error("event control read back wrong");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !pready && !xfer_start && !xfer_abort && !irq)
    else $error("outputs active after reset");
endmodule
bind dcec_top dcec_checker #(.N_IRQ(N_IRQ), .SEL_W(SEL_W)) u_dcec_checker (
  .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .irq_pulse, .pattern_match, .xfer_start, .xfer_abort,
  .channel_enable_clr, .abort_event_flag_set, .irq);

// [verification/dcec_top_test.sv]
// Self-checking testbench for the channel event control block
`timescale 1ns/10ps
module dcec_top_test;
  import dcec_pkg::*;
  // -----------------------------------------------------------
  // Signals
  // -----------------------------------------------------------
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [255:0] irq_pulse = '0;
  logic         match_req = 1'b0;
  logic         pready, pslverr, xfer_busy, pattern_match, irq;
  logic         xfer_start, xfer_abort, channel_enable_clr;
  logic         abort_event_flag_set;
  logic [31:0]  prdata, rd, r32;
  logic         err, gs, ga;
  logic [7:0]   sa, ss, idx;
  logic [2:0]   en;
  int           mismatches = 0;
  int           comparisons = 0;
  integer       seed = 74917;
  always #2.5 sys_clk = ~sys_clk;
  dcec_top dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .irq_pulse, .xfer_busy, .pattern_match,
    .xfer_start, .xfer_abort, .channel_enable_clr, .abort_event_flag_set,
    .irq);
  dcec_engine_model u_eng (.sys_clk, .rst, .xfer_start, .xfer_abort,
    .match_req, .xfer_busy, .pattern_match);
  // -----------------------------------------------------------
  // Tasks and expectations
  // -----------------------------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits a few cycles for a command pulse; latency is the design's
  task wait_out;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (xfer_start !== 1'b1 && xfer_abort !== 1'b1 && n < 4);
    gs = xfer_start;
    ga = xfer_abort;
  endtask
  // One-cycle request pulse; outputs settle after the next edge
  task pulse(input logic [7:0] i);
    @(posedge sys_clk);
    irq_pulse[i] <= 1'b1;
    @(posedge sys_clk);
    irq_pulse <= '0;
    #1;
  endtask
  function logic [31:0] econ(input logic [7:0] a, s, input logic [2:0] e);
    return {8'h00, a, s, 2'b00, e, 3'b000};
  endfunction
  task end_sim;
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    apb(0, DCEC_OFF_ECON, 0);
    chk("econ reset", rd, 32'h00ffff00);
    apb(0, 8'h10, 0);
    chk("unmapped", err, 1);
    // All ones: reserved bits drop, commands read zero, abort wins
    apb(1, DCEC_OFF_ECON, 32'hffffffff);
    wait_out();
    chk("both commands", {gs, ga}, 2'b01);
    apb(0, DCEC_OFF_ECON, 0);
    chk("econ ones", rd, econ(8'hff, 8'hff, 3'b111));
    // Random selectors, start and abort enables, and request numbers
    repeat (24) begin
      sa = 8'($random(seed));
      ss = 8'($random(seed));
      if (ss == sa) ss = sa + 8'h01;
      en = 3'($random(seed)) & 3'b011;
      r32 = $random(seed);
      apb(1, DCEC_OFF_ECON, {r32[31:24], sa, ss, 2'b00, en, r32[2:0]});
      apb(0, DCEC_OFF_ECON, 0);
      chk("econ", rd, econ(sa, ss, en));
      case ($random(seed) & 3)
        0: idx = ss;
        1: idx = sa;
        default: idx = 8'($random(seed));
      endcase
      pulse(idx);
      chk("start", xfer_start, idx == ss && en[1] && idx != sa);
      chk("abort", xfer_abort, idx == sa && en[0]);
      chk("flag", abort_event_flag_set, idx == sa && en[0]);
    end
    // Force start, engine busy seen in live state
    apb(1, DCEC_OFF_ECON, 32'h80);
    wait_out();
    chk("force", {gs, ga}, 2'b10);
    apb(0, DCEC_OFF_LIVE, 0);
    chk("busy", rd[0], 1);
    // Zero commands do nothing
    apb(1, DCEC_OFF_ECON, 32'h0);
    wait_out();
    chk("zero cmd", {gs, ga}, 2'b00);
    // Pattern match with the enable clear, then set
    for (int p = 0; p < 2; p++) begin
      apb(1, DCEC_OFF_ECON, p ? 32'ha0 : 32'h80);
      wait_out();
      @(posedge sys_clk);
      match_req <= 1'b1;
      @(posedge sys_clk);
      match_req <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("enable clear", channel_enable_clr, p);
      chk("pattern abort", xfer_abort, p);
    end
    // Interrupt: masked stays low, unmasked rises, clear drops
    apb(1, DCEC_OFF_ECON, 32'h0510);
    apb(1, DCEC_OFF_STAT, 32'h1f);
    apb(1, DCEC_OFF_MASK, 32'h0);
    pulse(8'h05);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq masked", irq, 0);
    apb(0, DCEC_OFF_STAT, 0);
    chk("status", rd[0], 1);
    apb(1, DCEC_OFF_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq", irq, 1);
    apb(1, DCEC_OFF_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq cleared", irq, 0);
    // Second reset brings back reset values
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    apb(0, DCEC_OFF_ECON, 0);
    chk("econ rereset", rd, 32'h00ffff00);
    end_sim();
  end
endmodule
